// ---- irq_trigger_mask_steering.sv ----
// trigger select, masking, status reads and shared-line steering of the cascaded interrupt pair
`timescale 1ns/1ps
`default_nettype none
module irq_trigger_mask_steering
    import irq_steer_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    input  wire logic [15:0] io_addr_i,
    input  wire logic [7:0]  io_wdata_i,
    input  wire logic        io_wr_i,
    input  wire logic        io_rd_i,
    input  wire logic [15:0] irq_i,
    input  wire logic [3:0]  shared_lines_n_i,
    input  wire logic        interrupt_ack_strobe_i,
    output var  logic        intr_o,
    output var  logic [7:0]  io_rdata_o,
    output var  logic        ack_valid_o,
    output var  logic [3:0]  ack_vector_o,
    output var  logic        ack_spurious_o
);

    top_t        st_reg;
    top_t        st_next;
    logic [15:0] routed;
    logic [7:0]  req_m;
    logic [7:0]  req_s;
    logic [7:0]  en_m;
    logic [7:0]  en_s;
    logic [7:0]  grant_m;
    logic [7:0]  grant_s;

    // ****************************************************************
    // shared line steering
    // ****************************************************************
    shared_line_router u_router (
        .clock_i          (clock_i),
        .rst_n_i          (rst_n_i),
        .shared_lines_n_i (shared_lines_n_i),
        .route_i          (st_reg.route),
        .routed_o         (routed)
    );

    // ****************************************************************
    // request lines and priority
    // ****************************************************************
    // slave output is fed to master input 2, so a master mask there gates the slave
    always_comb begin
        en_s    = enabled(st_reg.c[1]);
        en_m    = enabled(st_reg.c[0]);
        req_s   = irq_i[15:8] | routed[15:8];
        req_m   = irq_i[7:0] | routed[7:0];
        req_m[CASCADE_INPUT] = |en_s;
        grant_m = first_bit(en_m);
        grant_s = first_bit(en_s);
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        logic [1:0][7:0] take;
        logic [7:0]      r;
        logic [7:0]      rise;
        logic [7:0]      trig;
        logic [7:0]      eos_clr;
        logic [15:0]     cmd_addr;
        logic [15:0]     data_addr;
        logic [15:0]     trig_addr;
        logic            poll_rd;
        take      = '0;
        r         = 8'h00;
        rise      = 8'h00;
        trig      = 8'h00;
        eos_clr   = 8'h00;
        cmd_addr  = MASTER_CMD_ADDR;
        data_addr = MASTER_DATA_ADDR;
        trig_addr = TRIG_MASTER_ADDR;
        poll_rd   = 1'b0;
        st_next   = st_reg;
        st_next.ack_valid = interrupt_ack_strobe_i;
        st_next.intr      = |en_m;

        // acknowledge: master first, then slave when the cascade input wins
        if (interrupt_ack_strobe_i) begin
            take[0]      = grant_m;
            st_next.spur = 1'b0;
            if (grant_m == 8'h00) begin
                st_next.vec  = {1'b0, DEFAULT_LEVEL};
                st_next.spur = 1'b1;
            end else if (grant_m[CASCADE_INPUT]) begin
                take[1] = grant_s;
                if (grant_s == 8'h00) begin
                    st_next.vec  = {1'b1, DEFAULT_LEVEL};
                    st_next.spur = 1'b1;
                end else begin
                    st_next.vec = {1'b1, bit_index(grant_s)};
                end
            end else begin
                st_next.vec = {1'b0, bit_index(grant_m)};
            end
        end

        if (io_rd_i) begin
            st_next.rdata = 8'h00;
        end
        for (int k = 0; k < 4; k++) begin
            if (io_rd_i && io_addr_i == ROUTE_BASE_ADDR + 16'(k)) begin
                st_next.rdata = st_reg.route[k];
            end
            if (io_wr_i && io_addr_i == ROUTE_BASE_ADDR + 16'(k)) begin
                st_next.route[k] = io_wdata_i;
            end
        end

        // each controller: request capture, reads and command words
        for (int c = 0; c < 2; c++) begin
            r         = (c == 0) ? req_m : req_s;
            cmd_addr  = (c == 0) ? MASTER_CMD_ADDR : SLAVE_CMD_ADDR;
            data_addr = (c == 0) ? MASTER_DATA_ADDR : SLAVE_DATA_ADDR;
            trig_addr = (c == 0) ? TRIG_MASTER_ADDR : TRIG_SLAVE_ADDR;
            trig      = st_reg.c[c].trig;
            rise      = r & ~st_reg.c[c].prev;
            poll_rd   = io_rd_i && io_addr_i == cmd_addr && st_reg.c[c].poll;
            if (poll_rd) begin
                take[c] = take[c] | first_bit(enabled(st_reg.c[c]));
            end
            st_next.c[c].prev = r;
            // a new edge in the clearing cycle survives the clear
            st_next.c[c].pending_request_status = (~trig & ((st_reg.c[c].pending_request_status & r & ~take[c]) | rise))
                             | (trig & r);
            st_next.c[c].in_service_status = st_reg.c[c].in_service_status | take[c];

            // status and mask reads
            if (io_rd_i && io_addr_i == cmd_addr) begin
                st_next.c[c].poll = 1'b0;
                if (st_reg.c[c].poll) begin
                    st_next.rdata = {|enabled(st_reg.c[c]), 4'h0,
                                     bit_index(first_bit(enabled(st_reg.c[c])))};
                end else if (st_reg.c[c].read_isr) begin
                    st_next.rdata = st_reg.c[c].in_service_status;
                end else begin
                    st_next.rdata = st_reg.c[c].pending_request_status;
                end
            end
            if (io_rd_i && io_addr_i == data_addr) begin
                st_next.rdata = st_reg.c[c].channel_mask;
            end
            if (io_rd_i && io_addr_i == trig_addr) begin
                st_next.rdata = st_reg.c[c].trig;
            end
            if (io_wr_i && io_addr_i == trig_addr) begin
                st_next.c[c].trig = io_wdata_i & TRIG_WRITABLE[c];
            end

            // command port writes
            if (io_wr_i && io_addr_i == cmd_addr) begin
                if (io_wdata_i[INIT_WORD_BIT]) begin
                    // the global trigger bit is dropped here on purpose
                    st_next.c[c].channel_mask       = 8'h00;
                    st_next.c[c].in_service_status       = 8'h00;
                    st_next.c[c].special_mask_select       = 1'b0;
                    st_next.c[c].read_isr  = 1'b0;
                    st_next.c[c].poll      = 1'b0;
                    st_next.c[c].init_step = INIT_WORD2;
                    st_next.c[c].need_w4   = io_wdata_i[INIT_NEED_W4_BIT];
                end else if (io_wdata_i[THIRD_OPERATION_WORD_ID_BIT]) begin
                    if (io_wdata_i[MASK_MODE_WE_BIT]) begin
                        st_next.c[c].special_mask_select = io_wdata_i[SPECIAL_MASK_SEL_BIT];
                    end
                    if (io_wdata_i[STATUS_READ_CMD_BIT]) begin
                        st_next.c[c].read_isr = io_wdata_i[IN_SERVICE_SEL_BIT];
                    end
                    st_next.c[c].poll = io_wdata_i[POLL_BIT];
                end else if (io_wdata_i[EOS_BIT]) begin
                    // in special mask mode a masked level is skipped by the non-specific form
                    if (io_wdata_i[EOS_SPECIFIC_BIT]) begin
                        eos_clr = 8'h01 << io_wdata_i[2:0];
                    end else begin
                        eos_clr = first_bit(st_reg.c[c].in_service_status & ~(st_reg.c[c].special_mask_select ? st_reg.c[c].channel_mask : 8'h00));
                    end
                    // an acknowledge landing in the same cycle as the clear still sets its bit
                    st_next.c[c].in_service_status = (st_reg.c[c].in_service_status & ~eos_clr) | take[c];
                end
            end

            // data port writes: init sequence first, then mask
            if (io_wr_i && io_addr_i == data_addr) begin
                unique case (st_reg.c[c].init_step)
                    INIT_WORD2: begin
                        st_next.c[c].init_step = INIT_WORD3;
                    end
                    INIT_WORD3: begin
                        st_next.c[c].init_step = st_reg.c[c].need_w4 ? INIT_WORD4 : INIT_IDLE;
                    end
                    INIT_WORD4: begin
                        st_next.c[c].init_step = INIT_IDLE;
                    end
                    INIT_IDLE: begin
                        st_next.c[c].channel_mask = io_wdata_i;
                    end
                endcase
            end
        end
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    // everything starts edge-triggered, unmasked and reading the request register
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_reg <= '0;
            for (int c = 0; c < 2; c++) begin
                st_reg.c[c].trig <= TRIG_RESET;
            end
            for (int k = 0; k < 4; k++) begin
                st_reg.route[k] <= ROUTE_RESET;
            end
        end else begin
            st_reg <= st_next;
        end
    end

    assign intr_o         = st_reg.intr;
    assign io_rdata_o     = st_reg.rdata;
    assign ack_valid_o    = st_reg.ack_valid;
    assign ack_vector_o   = st_reg.vec;
    assign ack_spurious_o = st_reg.spur;

    // ****************************************************************
    // checks
    // ****************************************************************
    property p_edge_once;
        @(posedge clock_i) disable iff (!rst_n_i)
            (!st_reg.c[0].trig[5] && st_reg.c[0].prev[5] && req_m[5] && !st_reg.c[0].pending_request_status[5])
            |=> !st_reg.c[0].pending_request_status[5];
    endproperty
    a_edge_once: assert property (p_edge_once) else $error("held edge input raised a request");

    property p_level_follows;
        @(posedge clock_i) disable iff (!rst_n_i)
            (st_reg.c[0].trig[3] && req_m[3]) |=> st_reg.c[0].pending_request_status[3];
    endproperty
    a_level_follows: assert property (p_level_follows) else $error("level request not captured");

    property p_fixed_edge;
        @(posedge clock_i) disable iff (!rst_n_i)
            st_reg.c[0].trig[2:0] == 3'h0 && !st_reg.c[1].trig[0] && !st_reg.c[1].trig[5];
    endproperty
    a_fixed_edge: assert property (p_fixed_edge) else $error("fixed input left edge mode");

    property p_spurious;
        @(posedge clock_i) disable iff (!rst_n_i)
            (interrupt_ack_strobe_i && en_m == 8'h00)
            |=> ack_valid_o && ack_spurious_o && ack_vector_o == 4'h7 && st_reg.c[0].in_service_status == $past(st_reg.c[0].in_service_status);
    endproperty
    a_spurious: assert property (p_spurious) else $error("default acknowledge wrong");

    property p_real_seven;
        @(posedge clock_i) disable iff (!rst_n_i)
            (interrupt_ack_strobe_i && grant_m == 8'h80) |=> st_reg.c[0].in_service_status[7] && !ack_spurious_o;
    endproperty
    a_real_seven: assert property (p_real_seven) else $error("level 7 in-service not set");

    property p_isr_on_ack;
        @(posedge clock_i) disable iff (!rst_n_i)
            (interrupt_ack_strobe_i && grant_m != 8'h00 && !io_wr_i)
            |=> (st_reg.c[0].in_service_status & $past(grant_m)) == $past(grant_m);
    endproperty
    a_isr_on_ack: assert property (p_isr_on_ack) else $error("acknowledged level not in service");

    property p_mask_blocks;
        @(posedge clock_i) disable iff (!rst_n_i)
            (interrupt_ack_strobe_i && st_reg.c[0].channel_mask[3]) |=> ack_vector_o != 4'h3;
    endproperty
    a_mask_blocks: assert property (p_mask_blocks) else $error("masked channel acknowledged");

    property p_cascade_mask;
        @(posedge clock_i) disable iff (!rst_n_i)
            (interrupt_ack_strobe_i && st_reg.c[0].channel_mask[2]) |=> !ack_vector_o[3];
    endproperty
    a_cascade_mask: assert property (p_cascade_mask) else $error("slave served through masked input");

    property p_smm_set;
        @(posedge clock_i) disable iff (!rst_n_i)
            (io_wr_i && io_addr_i == MASTER_CMD_ADDR && io_wdata_i[7:3] == 5'b01101) |=> st_reg.c[0].special_mask_select;
    endproperty
    a_smm_set: assert property (p_smm_set) else $error("special mask mode not set");

    property p_select_holds;
        @(posedge clock_i) disable iff (!rst_n_i)
            !(io_wr_i && io_addr_i == MASTER_CMD_ADDR) |=> $stable(st_reg.c[0].read_isr);
    endproperty
    a_select_holds: assert property (p_select_holds) else $error("status selection moved");

    property p_status_default;
        @(posedge clock_i) disable iff (!rst_n_i)
            (io_wr_i && io_addr_i == MASTER_CMD_ADDR && io_wdata_i[INIT_WORD_BIT])
            |=> !st_reg.c[0].read_isr && !st_reg.c[0].poll;
    endproperty
    a_status_default: assert property (p_status_default) else $error("status selection not reset");

    property p_mask_read;
        @(posedge clock_i) disable iff (!rst_n_i)
            (io_rd_i && io_addr_i == SLAVE_DATA_ADDR) |=> io_rdata_o == $past(st_reg.c[1].channel_mask);
    endproperty
    a_mask_read: assert property (p_mask_read) else $error("mask read mismatch");

    c_spurious: cover property (@(posedge clock_i) disable iff (!rst_n_i) ack_valid_o && ack_spurious_o);
    c_slave_ack: cover property (@(posedge clock_i) disable iff (!rst_n_i) ack_valid_o && ack_vector_o[3] && !ack_spurious_o);
    c_smm: cover property (@(posedge clock_i) disable iff (!rst_n_i) st_reg.c[0].special_mask_select && |st_reg.c[0].in_service_status);
    c_routed: cover property (@(posedge clock_i) disable iff (!rst_n_i) |routed);
    c_poll: cover property (@(posedge clock_i) disable iff (!rst_n_i)
        io_rd_i && io_addr_i == MASTER_CMD_ADDR && st_reg.c[0].poll);

endmodule
`default_nettype wire

// ---- irq_steer_pkg.sv ----
// constants, types and decode functions of the interrupt trigger, mask and steering block
package irq_steer_pkg;

    // ****************************************************************
    // port map
    // ****************************************************************
    localparam logic [15:0] MASTER_CMD_ADDR   = 16'h0020;
    localparam logic [15:0] MASTER_DATA_ADDR  = 16'h0021;
    localparam logic [15:0] SLAVE_CMD_ADDR    = 16'h00A0;
    localparam logic [15:0] SLAVE_DATA_ADDR   = 16'h00A1;
    localparam logic [15:0] TRIG_MASTER_ADDR  = 16'h04D0;
    localparam logic [15:0] TRIG_SLAVE_ADDR   = 16'h04D1;
    localparam logic [15:0] ROUTE_BASE_ADDR   = 16'h04E0;

    // ****************************************************************
    // command word fields
    // ****************************************************************
    localparam int INIT_WORD_BIT        = 4;  // first_init_word when set at the command port
    localparam int INIT_NEED_W4_BIT     = 0;
    localparam int THIRD_OPERATION_WORD_ID_BIT          = 3;  // third_operation_word when set (and bit 4 clear)
    localparam int MASK_MODE_WE_BIT     = 6;  // mask_mode_write_enable
    localparam int SPECIAL_MASK_SEL_BIT = 5;  // special_mask_select
    localparam int POLL_BIT             = 2;
    localparam int STATUS_READ_CMD_BIT  = 1;  // status_read_command
    localparam int IN_SERVICE_SEL_BIT   = 0;  // in_service_read_select
    localparam int EOS_SPECIFIC_BIT     = 6;
    localparam int EOS_BIT              = 5;
    localparam int ROUTE_DISABLE_BIT    = 7;

    // ****************************************************************
    // fixed values
    // ****************************************************************
    localparam logic [1:0][7:0] TRIG_WRITABLE  = {8'hDE, 8'hF8};  // inputs 0,1,2,8,13 stay edge
    localparam logic [7:0]      TRIG_RESET     = 8'h00;           // all edge
    localparam logic [7:0]      ROUTE_RESET    = 8'h80;           // steering off
    localparam logic [15:0]     LEGAL_TARGETS  = 16'hDEF8;        // 15,14,12-9,7-3
    localparam logic [2:0]      DEFAULT_LEVEL  = 3'h7;
    localparam int              CASCADE_INPUT  = 2;
    localparam logic [1:0]      INIT_IDLE      = 2'h0;
    localparam logic [1:0]      INIT_WORD2     = 2'h1;
    localparam logic [1:0]      INIT_WORD3     = 2'h2;
    localparam logic [1:0]      INIT_WORD4     = 2'h3;

    typedef struct packed {
        logic [7:0] pending_request_status;
        logic [7:0] in_service_status;
        logic [7:0] channel_mask;
        logic [7:0] trig;
        logic [7:0] prev;
        logic       special_mask_select;
        logic       read_isr;
        logic       poll;
        logic [1:0] init_step;
        logic       need_w4;
    } ctrl_t;

    typedef struct packed {
        ctrl_t [1:0]      c;
        logic [3:0][7:0]  route;
        logic             intr;
        logic [7:0]       rdata;
        logic             ack_valid;
        logic [3:0]       vec;
        logic             spur;
    } top_t;

    typedef struct packed {
        logic [3:0]  s1;
        logic [3:0]  s2;
        logic [15:0] routed;
    } route_state_t;

    // lowest index set bit is the highest priority
    function automatic logic [7:0] first_bit(input logic [7:0] v);
        return v & (~v + 8'h01);
    endfunction

    function automatic logic [2:0] bit_index(input logic [7:0] onehot);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = 0; i < 8; i++) begin
            if (onehot[i]) begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction

    // requests allowed through mask and in-service blocking
    function automatic logic [7:0] enabled(input ctrl_t s);
        logic [7:0] allow;
        allow = s.special_mask_select ? 8'hFF : (first_bit(s.in_service_status) - 8'h01);
        return s.pending_request_status & ~s.channel_mask & allow;
    endfunction

endpackage

// ---- shared_line_router.sv ----
// synchroniser and router of the shared active-low interrupt lines
`timescale 1ns/1ps
`default_nettype none
module shared_line_router
    import irq_steer_pkg::*;
(
    input  wire logic            clock_i,
    input  wire logic            rst_n_i,
    input  wire logic [3:0]      shared_lines_n_i,
    input  wire logic [3:0][7:0] route_i,
    output var  logic [15:0]     routed_o
);

    route_state_t st_reg;
    route_state_t st_next;

    // ****************************************************************
    // routing
    // ****************************************************************
    // second stage only feeds the mux; first stage is read by nothing else
    always_comb begin
        st_next        = st_reg;
        st_next.s1     = shared_lines_n_i;
        st_next.s2     = st_reg.s1;
        st_next.routed = 16'h0000;
        for (int k = 0; k < 4; k++) begin
            if (!route_i[k][ROUTE_DISABLE_BIT] && LEGAL_TARGETS[route_i[k][3:0]]) begin
                st_next.routed[route_i[k][3:0]] = st_next.routed[route_i[k][3:0]] | ~st_reg.s2[k];
            end
        end
    end

    // lines idle high, so reset holds them released
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_reg <= '{s1: 4'hF, s2: 4'hF, routed: 16'h0000};
        end else begin
            st_reg <= st_next;
        end
    end

    assign routed_o = st_reg.routed;

    // ****************************************************************
    // checks
    // ****************************************************************
    property p_only_legal;
        @(posedge clock_i) disable iff (!rst_n_i) (routed_o & ~LEGAL_TARGETS) == 16'h0000;
    endproperty
    a_only_legal: assert property (p_only_legal) else $error("routed to illegal input");

    property p_disabled_quiet;
        @(posedge clock_i) disable iff (!rst_n_i)
            (route_i[0][7] && route_i[1][7] && route_i[2][7] && route_i[3][7]) |=> routed_o == 16'h0000;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet) else $error("disabled route drove a request");

endmodule
`default_nettype wire

// ---- irq_source_model.sv ----
// model of the request sources and the processor acknowledge side
`timescale 1ns/1ps
`default_nettype none
module irq_source_model (
    input  wire logic        clock_i,
    input  wire logic [15:0] req_i,
    input  wire logic [3:0]  shared_req_i,
    input  wire logic        ack_go_i,
    output var  logic [15:0] irq_o,
    output var  logic [3:0]  shared_lines_n_o,
    output var  logic        ack_strobe_o
);
    // idle sources at time zero so the block never sees unknown requests
    initial begin
        irq_o = 16'h0000;
        shared_lines_n_o = 4'hF;
        ack_strobe_o = 1'b0;
    end
    // sources hold their level until the bench drops it, with or without a strobe; only the strobe is cut to one cycle
    always @(negedge clock_i) begin
        irq_o <= req_i;
        shared_lines_n_o <= ~shared_req_i;
        ack_strobe_o <= ack_go_i & ~ack_strobe_o;
    end
endmodule
`default_nettype wire

// ---- irq_trigger_mask_steering_test.sv ----
// self-checking bench of the trigger, mask and steering block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin bad_count++; \
    $display("wrong value %s exp %h got %h", nm, ex, gt); end end
module irq_trigger_mask_steering_test
    import irq_steer_pkg::*;
;
    logic        clock_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic [15:0] io_addr_i = 16'h0000;
    logic [7:0]  io_wdata_i = 8'h00;
    logic        io_wr_i = 1'b0;
    logic        io_rd_i = 1'b0;
    logic [15:0] req = 16'h0000;
    logic [3:0]  shared_req = 4'h0;
    logic        ack_go = 1'b0;
    wire  [15:0] irq_i;
    wire  [3:0]  shared_n;
    wire         strobe;
    wire         intr_o;
    wire  [7:0]  io_rdata_o;
    wire         ack_valid_o;
    wire  [3:0]  ack_vector_o;
    wire         ack_spurious_o;
    int          bad_count = 0;
    int          tests_run = 0;

    always #10 clock_i = ~clock_i;

    irq_source_model u_irq_source_model (.clock_i(clock_i), .req_i(req), .shared_req_i(shared_req),
        .ack_go_i(ack_go), .irq_o(irq_i), .shared_lines_n_o(shared_n), .ack_strobe_o(strobe));
    irq_trigger_mask_steering u_irq_trigger_mask_steering (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .io_addr_i(io_addr_i), .io_wdata_i(io_wdata_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i),
        .irq_i(irq_i), .shared_lines_n_i(shared_n), .interrupt_ack_strobe_i(strobe), .intr_o(intr_o),
        .io_rdata_o(io_rdata_o), .ack_valid_o(ack_valid_o), .ack_vector_o(ack_vector_o),
        .ack_spurious_o(ack_spurious_o));

    // ****************************************************************
    // bus and acknowledge tasks, all driven on the falling edge
    // ****************************************************************
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic do_reset();
        @(negedge clock_i);
        rst_n_i <= 1'b0;
        req <= 16'h0000;
        shared_req <= 4'h0;
        repeat (5) @(negedge clock_i);
        rst_n_i <= 1'b1;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clock_i);
        io_addr_i <= a;
        io_wdata_i <= d;
        io_wr_i <= 1'b1;
        @(negedge clock_i);
        io_wr_i <= 1'b0;
    endtask
    // read data is registered, so it is sampled one full cycle after the strobe
    task automatic rd(input logic [15:0] a, input logic [7:0] ex);
        @(negedge clock_i);
        io_addr_i <= a;
        io_rd_i <= 1'b1;
        @(negedge clock_i);
        io_rd_i <= 1'b0;
        @(negedge clock_i);
        `CHK("read data", ex, io_rdata_o)
    endtask
    // answer pulse stands one cycle only, checked inside that cycle
    task automatic ack(input logic [3:0] vec, input logic spur);
        @(negedge clock_i);
        ack_go <= 1'b1;
        @(negedge clock_i);
        ack_go <= 1'b0;
        @(negedge clock_i);
        `CHK("ack valid", 1'b1, ack_valid_o)
        `CHK("ack vector", vec, ack_vector_o)
        `CHK("ack spurious", spur, ack_spurious_o)
    endtask
    task automatic wait_intr();
        int n;
        n = 0;
        while (intr_o !== 1'b1 && n < 20) begin
            @(negedge clock_i);
            n++;
        end
        `CHK("interrupt output", 1'b1, intr_o)
        if (intr_o !== 1'b1) close_out();
    endtask

    // ****************************************************************
    // test sequence
    // ****************************************************************
    initial begin
        do_reset();
        wr(MASTER_CMD_ADDR, 8'h19);
        wr(MASTER_DATA_ADDR, 8'h08);
        wr(MASTER_DATA_ADDR, 8'h04);
        wr(MASTER_DATA_ADDR, 8'h01);
        wr(MASTER_DATA_ADDR, 8'hAA);
        rd(MASTER_DATA_ADDR, 8'hAA);
        rd(SLAVE_DATA_ADDR, 8'h00);
        rd(TRIG_MASTER_ADDR, 8'h00);
        wr(TRIG_MASTER_ADDR, 8'hFF);
        rd(TRIG_MASTER_ADDR, 8'hF8);
        wr(TRIG_SLAVE_ADDR, 8'hFF);
        rd(TRIG_SLAVE_ADDR, 8'hDE);
        rd(ROUTE_BASE_ADDR, 8'h80);
        rd(16'h04E7, 8'h00);
        $display("test registers done");
        do_reset();
        req <= 16'h0020;
        wait_intr();
        rd(MASTER_CMD_ADDR, 8'h20);
        ack(4'h5, 1'b0);
        rd(MASTER_CMD_ADDR, 8'h00);
        wr(MASTER_CMD_ADDR, 8'h0B);
        rd(MASTER_CMD_ADDR, 8'h20);
        rd(MASTER_CMD_ADDR, 8'h20);
        req <= 16'h0060;
        repeat (4) @(negedge clock_i);
        `CHK("interrupt output", 1'b0, intr_o)
        ack(4'h7, 1'b1);
        rd(MASTER_CMD_ADDR, 8'h20);
        wr(MASTER_CMD_ADDR, 8'h68);
        ack(4'h6, 1'b0);
        wr(MASTER_CMD_ADDR, 8'h48);
        wr(MASTER_CMD_ADDR, 8'h20);
        rd(MASTER_CMD_ADDR, 8'h40);
        req <= 16'h0070;
        repeat (3) @(negedge clock_i);
        req <= 16'h0060;
        repeat (4) @(negedge clock_i);
        ack(4'h7, 1'b1);
        req <= 16'h0068;
        wait_intr();
        wr(MASTER_CMD_ADDR, 8'h0E);
        rd(MASTER_CMD_ADDR, 8'h83);
        $display("test edge and status done");
        do_reset();
        wr(TRIG_MASTER_ADDR, 8'h08);
        req <= 16'h0008;
        wait_intr();
        ack(4'h3, 1'b0);
        rd(MASTER_CMD_ADDR, 8'h08);
        req <= 16'h0000;
        wr(MASTER_CMD_ADDR, 8'h20);
        wr(MASTER_DATA_ADDR, 8'h0C);
        req <= 16'h0400;
        repeat (4) @(negedge clock_i);
        `CHK("interrupt output", 1'b0, intr_o)
        rd(SLAVE_CMD_ADDR, 8'h04);
        ack(4'h7, 1'b1);
        wr(MASTER_DATA_ADDR, 8'h00);
        wait_intr();
        ack(4'hA, 1'b0);
        wr(SLAVE_CMD_ADDR, 8'h62);
        wr(SLAVE_CMD_ADDR, 8'h0B);
        rd(SLAVE_CMD_ADDR, 8'h00);
        $display("test level and mask done");
        do_reset();
        wr(TRIG_MASTER_ADDR, 8'h20);
        wr(ROUTE_BASE_ADDR, 8'h05);
        shared_req <= 4'h1;
        wait_intr();
        rd(MASTER_CMD_ADDR, 8'h20);
        wr(ROUTE_BASE_ADDR, 8'h85);
        repeat (4) @(negedge clock_i);
        rd(MASTER_CMD_ADDR, 8'h00);
        req <= 16'h0080;
        wait_intr();
        ack(4'h7, 1'b0);
        wr(MASTER_CMD_ADDR, 8'h0B);
        rd(MASTER_CMD_ADDR, 8'h80);
        $display("test steering done");
        close_out();
    end
endmodule
`default_nettype wire
